/* File: hw/mnx_defs.vh */
// constants shared by the multiply / negate execution datapath
`ifndef MNX_DEFS_VH
`define MNX_DEFS_VH

// ==========================================================
// register bus map (word index on reg_addr)
`define ADDR_W 4
`define DATA_W 16
`define OFF_CTRL 4'h0
`define OFF_WORKING 4'h1
`define OFF_BANK_SEL 4'h2
`define OFF_INDEX_BASE 4'h3
`define OFF_INSTR 4'h4
`define OFF_PRODUCT 4'h5
`define OFF_STATUS 4'h6
`define OFF_MEM_ADDR 4'h7
`define OFF_MEM_DATA 4'h8
`define OFF_PC 4'h9
`define OFF_EXEC_INFO 4'hA

// ==========================================================
// field positions
`define CTRL_EXT_EN_BIT 0
`define ST_CARRY_BIT 0
`define ST_DIGIT_CARRY_BIT 1
`define ST_ZERO_BIT 2
`define ST_OVERFLOW_BIT 3
`define ST_NEGATIVE_BIT 4
`define INFO_ILLEGAL_BIT 0
`define INFO_LAST_OP_LSB 1

// ==========================================================
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_ADDR 12'h000
`define RST_BANK 4'h0
`define RST_STATUS 5'h00

// ==========================================================
// instruction encodings
`define OPC_MASK 16'hFE00
`define OPC_MULTIPLY 16'h0200
`define OPC_NEGATE 16'h6C00
`define OPC_IDLE_ZERO 16'h0000
`define OPC_IDLE_NIBBLE 4'hF
`define ACCESS_SEL_BIT 8

// ==========================================================
// data memory addressing
`define DATA_AW 12
`define INDEX_LIMIT 8'h5F
`define ACCESS_LOW_BASE 12'h000
`define ACCESS_HIGH_BASE 12'hF00

// ==========================================================
// last-operation codes shown in the info register
`define LAST_NONE 2'h0
`define LAST_MULTIPLY 2'h1
`define LAST_NEGATE 2'h2
`define LAST_IDLE 2'h3

`endif

/* File: hw/operand_address_resolver.v */
// file-operand address resolution: access bank, banked space, indexed literal offset
`default_nettype none
`include "mnx_defs.vh"

module operand_address_resolver (
	// instruction fields
	input wire access_sel,
	input wire [7:0] file_addr,
	// addressing state
	input wire [3:0] bank_select_register,
	input wire ext_enable,
	input wire [`DATA_AW-1:0] index_base,
	// resolved location
	output reg [`DATA_AW-1:0] data_addr,
	output reg indexed_mode
);

	// ==========================================================
	// address selection
	// indexed wraps inside the data space instead of faulting, as the core has no trap
	always @* begin
		indexed_mode = 1'b0;
		if (access_sel) begin
			// banked space: bank select chooses the bank
			data_addr = {bank_select_register, file_addr};
		end else if (ext_enable && (file_addr <= `INDEX_LIMIT)) begin
			// indexed literal offset from the index base
			indexed_mode = 1'b1;
			data_addr = index_base + {4'h0, file_addr};
		end else if (file_addr <= `INDEX_LIMIT) begin
			// lower access bank half
			data_addr = `ACCESS_LOW_BASE | {4'h0, file_addr};
		end else begin
			// upper access bank half sits at the top of data space
			data_addr = `ACCESS_HIGH_BASE | {4'h0, file_addr};
		end
	end

endmodule
`default_nettype wire

/* File: hw/negate_flag_unit.v */
// two's-complement negate of one byte with arithmetic flag generation
`default_nettype none
`include "mnx_defs.vh"

module negate_flag_unit (
	// operand
	input wire [7:0] operand,
	// result and flags
	output wire [7:0] result,
	output wire [4:0] flags
);

	// ==========================================================
	// arithmetic: inverted value plus one, carries taken from the add
	wire [8:0] full_sum;
	wire [4:0] low_sum;

	assign full_sum = {1'b0, ~operand} + 9'h001;
	assign low_sum = {1'b0, ~operand[3:0]} + 5'h01;
	assign result = full_sum[7:0];

	// ==========================================================
	// flags packed at the status bit positions
	assign flags[`ST_CARRY_BIT] = full_sum[8];
	assign flags[`ST_DIGIT_CARRY_BIT] = low_sum[4];
	assign flags[`ST_ZERO_BIT] = (full_sum[7:0] == 8'h00);
	// only 80h overflows: its negation is not representable
	assign flags[`ST_OVERFLOW_BIT] = operand[7] & full_sum[7];
	assign flags[`ST_NEGATIVE_BIT] = full_sum[7];

endmodule
`default_nettype wire

/* File: hw/multiply_negate_exec.v */
// execution datapath for multiply-by-file, negate-file and the idle instruction
//
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
`include "mnx_defs.vh"

// Overview of operation
// - decode multiply-by-file from top bits 0000 001
// - unsigned working times byte into product pair
// - multiply leaves working register and byte alone
// - multiply changes no status flag
// - access bit 0 selects the access bank
// - access bit 1 uses bank select register
// - extended set, bit 0, f<=5Fh: indexed
// - negate 0110 110 writes two's complement
// - negate writes back, updates N OV C DC Z
module multiply_negate_exec (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// register bus
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [`DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`DATA_W-1:0] reg_rdata,
	// result view
	output reg [7:0] product_high,
	output reg [7:0] product_low,
	output reg [4:0] status_flags,
	output reg instr_retired
);

	// ==========================================================
	// reset release: asserted at once, released through two flops
	reg rst_meta_q;
	reg rst_sync_q;
	wire rstn_int;

	// the first flop only feeds the second
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rstn_int = rst_sync_q;

	// ==========================================================
	// architectural state
	reg ext_enable_q; // extended instruction set enable
	reg [7:0] working_q; // working register
	reg [3:0] bank_sel_q; // bank select register
	reg [`DATA_AW-1:0] index_base_q; // base for indexed literal offset
	reg [`DATA_AW-1:0] mem_addr_q; // software window into data memory
	reg [15:0] pc_q; // program counter, advanced per instruction
	reg illegal_q; // last issued word was not one of ours
	reg [1:0] last_op_q; // kind of the last retired instruction
	reg [15:0] instr_q; // last instruction word issued

	// data memory, no reset: contents belong to software
	reg [7:0] data_mem [0:(1 << `DATA_AW)-1];

	// ==========================================================
	// issue: a write to the instruction offset executes in that same cycle
	wire issue;
	wire [15:0] instr;
	wire is_multiply;
	wire is_negate;
	wire is_idle;

	assign issue = reg_wr && (reg_addr == `OFF_INSTR);
	assign instr = reg_wdata;
	assign is_multiply = ((instr & `OPC_MASK) == `OPC_MULTIPLY);
	assign is_negate = ((instr & `OPC_MASK) == `OPC_NEGATE);
	assign is_idle = (instr == `OPC_IDLE_ZERO) || (instr[15:12] == `OPC_IDLE_NIBBLE);

	// ==========================================================
	// operand location from access bit and file field
	wire [`DATA_AW-1:0] operand_addr;
	wire operand_indexed;

	operand_address_resolver u_resolver (
		.access_sel(instr[`ACCESS_SEL_BIT]),
		.file_addr(instr[7:0]),
		.bank_select_register(bank_sel_q),
		.ext_enable(ext_enable_q),
		.index_base(index_base_q),
		.data_addr(operand_addr),
		.indexed_mode(operand_indexed)
	);

	// operand byte, read combinationally so execution fits one cycle
	wire [7:0] operand_byte;

	assign operand_byte = data_mem[operand_addr];

	// ==========================================================
	// arithmetic
	wire [15:0] product; // full 16-bit unsigned product
	wire [7:0] negated;
	wire [4:0] negate_flags;

	assign product = {8'h00, working_q} * {8'h00, operand_byte};

	negate_flag_unit u_negate (
		.operand(operand_byte),
		.result(negated),
		.flags(negate_flags)
	);

	// ==========================================================
	// data memory writes: negate write-back or software window
	// strobes never coincide, so the two writers cannot collide
	always @(posedge ref_clk) begin
		if (issue && is_negate) begin
			data_mem[operand_addr] <= negated;
		end else if (reg_wr && (reg_addr == `OFF_MEM_DATA)) begin
			// software store through the window
			data_mem[mem_addr_q] <= reg_wdata[7:0];
		end
		// multiply never writes memory
	end

	// ==========================================================
	// configuration registers written by software
	always @(posedge ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			ext_enable_q <= 1'b0;
			bank_sel_q <= `RST_BANK;
			index_base_q <= `RST_ADDR;
			mem_addr_q <= `RST_ADDR;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFF_CTRL: begin
					ext_enable_q <= reg_wdata[`CTRL_EXT_EN_BIT];
				end
				`OFF_BANK_SEL: begin
					bank_sel_q <= reg_wdata[3:0];
				end
				`OFF_INDEX_BASE: begin
					index_base_q <= reg_wdata[`DATA_AW-1:0];
				end
				`OFF_MEM_ADDR: begin
					mem_addr_q <= reg_wdata[`DATA_AW-1:0];
				end
				default: begin
					// other offsets handled elsewhere
				end
			endcase
		end
	end

	// ==========================================================
	// working register: only software writes it, multiply keeps it
	always @(posedge ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			working_q <= `RST_BYTE;
		end else if (reg_wr && (reg_addr == `OFF_WORKING)) begin
			working_q <= reg_wdata[7:0];
		end
	end

	// ==========================================================
	// product pair: written by multiply only
	always @(posedge ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			product_high <= `RST_BYTE;
			product_low <= `RST_BYTE;
		end else if (issue && is_multiply) begin
			product_high <= product[15:8];
			product_low <= product[7:0];
		end
	end

	// ==========================================================
	// status flags: negate wins over a software write in the same cycle
	// (strobes are exclusive, so that case only arises by design change)
	always @(posedge ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			status_flags <= `RST_STATUS;
		end else if (issue && is_negate) begin
			status_flags <= negate_flags;
		end else if (reg_wr && (reg_addr == `OFF_STATUS)) begin
			status_flags <= reg_wdata[4:0];
		end
		// multiply and idle leave flags untouched, zero product included
	end

	// ==========================================================
	// program counter, last-op record and retire pulse
	always @(posedge ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			pc_q <= `RST_WORD;
			instr_q <= `RST_WORD;
			illegal_q <= 1'b0;
			last_op_q <= `LAST_NONE;
			instr_retired <= 1'b0;
		end else begin
			instr_retired <= 1'b0;
			if (issue) begin
				instr_q <= instr;
				instr_retired <= 1'b1;
				// every word advances the counter, unknown ones included
				pc_q <= pc_q + 16'h0001;
				if (is_multiply) begin
					last_op_q <= `LAST_MULTIPLY;
					illegal_q <= 1'b0;
				end else if (is_negate) begin
					last_op_q <= `LAST_NEGATE;
					illegal_q <= 1'b0;
				end else if (is_idle) begin
					last_op_q <= `LAST_IDLE;
					illegal_q <= 1'b0;
				end else begin
					// outside this datapath: nothing executes, flag it
					last_op_q <= `LAST_NONE;
					illegal_q <= 1'b1;
				end
			end else if (reg_wr && (reg_addr == `OFF_PC)) begin
				pc_q <= reg_wdata;
			end
		end
	end

	// ==========================================================
	// read data, valid in the cycle after the read strobe only
	reg [`DATA_W-1:0] rd_mux;

	// unmapped offsets read as zero
	always @* begin
		rd_mux = `RST_WORD;
		case (reg_addr)
			`OFF_CTRL: begin
				rd_mux[`CTRL_EXT_EN_BIT] = ext_enable_q;
			end
			`OFF_WORKING: begin
				rd_mux[7:0] = working_q;
			end
			`OFF_BANK_SEL: begin
				rd_mux[3:0] = bank_sel_q;
			end
			`OFF_INDEX_BASE: begin
				rd_mux[`DATA_AW-1:0] = index_base_q;
			end
			`OFF_INSTR: begin
				rd_mux = instr_q;
			end
			`OFF_PRODUCT: begin
				rd_mux = {product_high, product_low};
			end
			`OFF_STATUS: begin
				rd_mux[4:0] = status_flags;
			end
			`OFF_MEM_ADDR: begin
				rd_mux[`DATA_AW-1:0] = mem_addr_q;
			end
			`OFF_MEM_DATA: begin
				rd_mux[7:0] = data_mem[mem_addr_q];
			end
			`OFF_PC: begin
				rd_mux = pc_q;
			end
			`OFF_EXEC_INFO: begin
				rd_mux[`INFO_ILLEGAL_BIT] = illegal_q;
				rd_mux[`INFO_LAST_OP_LSB+1:`INFO_LAST_OP_LSB] = last_op_q;
			end
			default: begin
				rd_mux = `RST_WORD;
			end
		endcase
	end

	// data drops back to zero when no read was made
	always @(posedge ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			reg_rdata <= `RST_WORD;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= `RST_WORD;
		end
	end

	// indexed-mode indication is kept internal; the address already reflects it
	wire unused_indexed;

	assign unused_indexed = operand_indexed;

endmodule
`default_nettype wire

/* File: sim/mnx_monitor.sv */
// assertion checker for the multiply / negate execution datapath
`default_nettype none
`include "mnx_defs.vh"
module mnx_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register bus
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// result view
	input wire logic [7:0] product_high,
	input wire logic [7:0] product_low,
	input wire logic [4:0] status_flags,
	input wire logic instr_retired
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// decoded requests seen on the bus
	wire iss = reg_wr && reg_addr == `OFF_INSTR;
	wire mul = iss && (reg_wdata & `OPC_MASK) == `OPC_MULTIPLY;
	wire neg = iss && (reg_wdata & `OPC_MASK) == `OPC_NEGATE;
	wire idl = iss && (reg_wdata == `OPC_IDLE_ZERO || reg_wdata[15:12] == `OPC_IDLE_NIBBLE);
	wire st_wr = reg_wr && reg_addr == `OFF_STATUS;
	wire [15:0] prod = {product_high, product_low};
	// ==========================================================
	// properties
	property p_retire; iss |=> instr_retired; endproperty
	property p_pulse; instr_retired |-> $past(iss); endproperty
	property p_prod_hold; !mul |=> $stable(prod); endproperty
	property p_mul_flags; mul |=> $stable(status_flags); endproperty
	property p_idle; idl |=> $stable(status_flags) && $stable(prod); endproperty
	property p_flag_src; !neg && !st_wr |=> $stable(status_flags); endproperty
	// zero result only from zero operand, overflow only with a negative result
	property p_neg_flags;
		neg |=> status_flags[0] == status_flags[2] && (!status_flags[3] || status_flags[4]);
	endproperty
	property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
	property p_rd_prod; reg_rd && reg_addr == `OFF_PRODUCT |=> reg_rdata == $past(prod); endproperty
	a_retire: assert property (p_retire)
		else $error("no retire pulse after issue");
	a_pulse: assert property (p_pulse)
		else $error("retire pulse without issue");
	a_prod_hold: assert property (p_prod_hold)
		else $error("product changed without multiply");
	a_mul_flags: assert property (p_mul_flags)
		else $error("multiply changed status");
	a_idle: assert property (p_idle)
		else $error("idle word changed state");
	a_flag_src: assert property (p_flag_src)
		else $error("status changed without cause");
	a_neg_flags: assert property (p_neg_flags)
		else $error("inconsistent negate flags");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero when idle");
	a_rd_prod: assert property (p_rd_prod)
		else $error("product read mismatch");
	// main scenarios reached
	c_mul: cover property (mul);
	c_neg: cover property (neg);
	c_idle: cover property (idl);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the multiply / negate execution datapath
`default_nettype none
`include "mnx_defs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// stimulus and observed signals
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [7:0] product_high;
	logic [7:0] product_low;
	logic [4:0] status_flags;
	logic instr_retired;
	logic [15:0] last_p; // product left by the latest multiply
	logic [7:0] nv [6] = '{8'h3a, 8'h00, 8'h80, 8'h01, 8'h10, 8'hff}; // negate operands
	logic [15:0] iw [4] = '{16'h0000, 16'hf123, 16'hffff, 16'h0400}; // idle and unknown
	// info expected: idle records its code, the unknown word only raises illegal
	logic [15:0] ie [4] = '{16'h0006, 16'h0006, 16'h0006, 16'h0001};
	int errors = 0;
	int n_tests = 0;
	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;
	multiply_negate_exec i_dut (
		.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.product_high(product_high), .product_low(product_low),
		.status_flags(status_flags), .instr_retired(instr_retired)
	);
	// ==========================================================
	// bus and compare helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task exec(input logic [15:0] w);
		wr(`OFF_INSTR, w);
		#1 chk({15'h0000, instr_retired}, 16'h0001);
	endtask
	// ==========================================================
	// scenarios
	// status preset to a pattern with zero clear: a zero product must not set it
	task mul_case(input logic [15:0] w, input logic [11:0] ma, input logic [7:0] wv,
		input logic [7:0] d);
		last_p = wv * d;
		wr(`OFF_WORKING, {8'h00, wv});
		wr(`OFF_MEM_ADDR, {4'h0, ma});
		wr(`OFF_MEM_DATA, {8'h00, d});
		wr(`OFF_STATUS, 16'h000a);
		exec(w);
		chk({product_high, product_low}, last_p);
		rd(`OFF_PRODUCT, last_p);
		rd(`OFF_WORKING, {8'h00, wv});
		rd(`OFF_MEM_DATA, {8'h00, d});
		rd(`OFF_EXEC_INFO, 16'h0002);
		chk({11'h000, status_flags}, 16'h000a);
	endtask
	// operand placed in bank 3 at 45h, reached with the access bit set
	task neg_case(input logic [7:0] x);
		logic [7:0] r;
		r = ~x + 8'h01;
		wr(`OFF_MEM_ADDR, 16'h0345);
		wr(`OFF_MEM_DATA, {8'h00, x});
		exec(16'h6d45);
		chk({11'h000, status_flags}, {11'h000, r[7], x == 8'h80, r == 8'h00,
			x[3:0] == 4'h0, x == 8'h00});
		rd(`OFF_MEM_DATA, {8'h00, r});
		rd(`OFF_EXEC_INFO, 16'h0004);
	endtask
	// counter preset so that a single advance is visible
	task idle_case(input logic [15:0] w, input logic [15:0] info);
		wr(`OFF_MEM_DATA, 16'h005a);
		wr(`OFF_STATUS, 16'h0015);
		wr(`OFF_PC, 16'h1230);
		exec(w);
		chk({11'h000, status_flags}, 16'h0015);
		chk({product_high, product_low}, last_p);
		rd(`OFF_MEM_DATA, 16'h005a);
		rd(`OFF_PC, 16'h1231);
		rd(`OFF_EXEC_INFO, info);
		rd(`OFF_INSTR, w);
	endtask
	// ==========================================================
	// closing report
	task summarize;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bound on the whole run, a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		summarize;
	end
	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		wr(`OFF_BANK_SEL, 16'h0003);
		wr(`OFF_INDEX_BASE, 16'h0200);
		rd(`OFF_BANK_SEL, 16'h0003);
		rd(`OFF_INDEX_BASE, 16'h0200);
		mul_case(16'h0210, 12'h010, 8'he2, 8'hc4);
		mul_case(16'h0322, 12'h322, 8'hff, 8'hff);
		mul_case(16'h0270, 12'hf70, 8'h00, 8'h55);
		wr(`OFF_CTRL, 16'h0001);
		mul_case(16'h0210, 12'h210, 8'h12, 8'h34);
		mul_case(16'h025f, 12'h25f, 8'h0b, 8'h13);
		mul_case(16'h0260, 12'hf60, 8'h21, 8'h07);
		wr(`OFF_CTRL, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			neg_case(nv[i]);
		end
		for (int i = 0; i < 4; i++) begin
			idle_case(iw[i], ie[i]);
		end
		rd(4'hf, 16'h0000);
		summarize;
	end
endmodule
bind multiply_negate_exec mnx_monitor i_mon (
	.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.product_high(product_high), .product_low(product_low),
	.status_flags(status_flags), .instr_retired(instr_retired)
);
`default_nettype wire
